// >>> design/seq_cfg_pkg.sv
// Constants and carriers for the sequencer configuration register bank
`default_nettype none
package seq_cfg_pkg;
    localparam int          DATA_W          = 16;
    localparam int          CHANNELS        = 6;
    localparam int          STEP_W          = 5;
    // Command bytes
    localparam logic [7:0]  CMD_WRITE_GUARD = 8'h00;
    localparam logic [7:0]  CMD_CUSTOMER    = 8'h01;
    localparam logic [7:0]  CMD_ONOFF       = 8'h02;
    localparam logic [7:0]  CMD_RANGE       = 8'h03;
    // Write guard fields
    localparam int          GUARD_SOFT_BIT  = 0;
    localparam int          GUARD_PIN_BIT   = 1;
    localparam int          KEY_LSB         = 2;
    localparam int          KEY_W           = 14;
    localparam logic [13:0] KEY_RESET       = 14'h0eaa;
    localparam logic        SOFT_RESET      = 1'b1;
    localparam logic [15:0] CUSTOMER_RESET  = 16'h0000;
    // On/off control fields
    localparam int          CTRL_W          = 7;
    localparam int          SEQ_QUAL_BIT    = 0;
    localparam int          POLARITY_BIT    = 1;
    localparam int          ON_MASK_BIT     = 2;
    localparam int          SER_MASK_BIT    = 3;
    localparam int          SER_ON_BIT      = 4;
    localparam int          DISCH_START_BIT = 5;
    localparam int          MARGIN_BIT      = 6;
    localparam logic [6:0]  CTRL_RESET      = 7'h00;
    // Range select
    localparam int          RANGE_W         = 12;
    localparam logic [11:0] RANGE_RESET     = 12'h055;
    localparam logic [1:0]  RANGE_HIGH      = 2'h0;
    localparam logic [1:0]  RANGE_LOW       = 2'h1;
    localparam logic [1:0]  RANGE_ADJ_POS   = 2'h2;
    localparam logic [1:0]  RANGE_ADJ_NEG   = 2'h3;
    // Threshold step per code, in millivolts
    localparam logic [4:0]  STEP_HIGH_MV    = 5'h14;
    localparam logic [4:0]  STEP_LOW_MV     = 5'h0a;
    localparam logic [4:0]  STEP_ADJ_MV     = 5'h04;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } cmd_t;

    typedef struct packed {
        logic        ack;
        logic [15:0] data;
    } resp_t;

    function automatic logic [4:0] rangeStep(input logic [1:0] sel);
        unique case (sel)
            RANGE_HIGH: rangeStep = STEP_HIGH_MV;
            RANGE_LOW:  rangeStep = STEP_LOW_MV;
            default:    rangeStep = STEP_ADJ_MV;
        endcase
    endfunction : rangeStep
endpackage : seq_cfg_pkg
`default_nettype wire

// >>> design/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync
    import seq_cfg_pkg::*;
#(
    parameter int           WIDTH = 3,
    parameter logic [2:0]   INIT  = 3'h0
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1 <= INIT[WIDTH-1:0];
            stage2 <= INIT[WIDTH-1:0];
            stage3 <= INIT[WIDTH-1:0];
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Stage one feeds stage two only; agreement of two and three counts
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            level <= INIT[WIDTH-1:0];
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end
endmodule : pin_sync
`default_nettype wire

// >>> design/range_decode.sv
// Per-channel comparator range decode: step size and discharge polarity
`default_nettype none
module range_decode
    import seq_cfg_pkg::*;
(
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic [RANGE_W-1:0]         rangeSel,
    output logic      [CHANNELS*STEP_W-1:0] stepMv,
    output logic      [CHANNELS-1:0]        dischargeNegative
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stepMv            <= '0;
            dischargeNegative <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                stepMv[c*STEP_W +: STEP_W] <= rangeStep(rangeSel[2*c +: 2]);
                dischargeNegative[c] <= (rangeSel[2*c +: 2] == RANGE_ADJ_NEG);
            end
        end
    end
endmodule : range_decode
`default_nettype wire

// >>> design/sequencer_control_config_regs.sv
// Configuration register bank of the six-channel supply sequencer
//
// Overview of operation
// - Any set software or pin lock blocks every configuration write except a key-match unlock of the guard word under soft lock alone.
// - Soft lock clears only on key match in 15:2 with 1:0 zero.
// - Bit 1 of the guard word reads the live write-protect pin.
// - Key may change only while unlocked; locked key stays unchanged.
// - Reads always allowed; protected writes acknowledged but change nothing.
// - Reset key is 0x0EAA and soft lock resets to locked.
// - Customer word is a scratchpad, reset value zero.
// - Control bit 7 reads internal on state, held by freeze.
// - Margin bit or margin pin lets reset output pull high.
// - Discharge-start bit blocks sequence-up until selected supplies discharged.
// - Serial on bit 4 obeyed only while mask bit 3 set.
// - Both masks clear holds down; both set needs serial and pin.
// - Mask bit 2 clear ignores on pin; set listens to it.
// - Polarity bit inverts on pin sense, taking effect at once.
// - Event mode advances position once members fall below discharge.
// - Time mode advances after fall time; infinite timer waits decay.
// - Two-bit range per channel; 5,6 reset high, 1-4 low.
// - Range applies to both comparators; discharge polarity follows it.
// - Step per code is 20, 10 or 4 millivolts by range.
// - Commands 0x00 to 0x03 reach the four configuration words.
`default_nettype none
module sequencer_control_config_regs
    import seq_cfg_pkg::*;
(
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire cmd_t                       cmd,
    output resp_t                           resp,
    input  wire logic                       writeProtectPin,
    input  wire logic                       onPin,
    input  wire logic                       margin_input_n,
    input  wire logic                       freezeMode,
    input  wire logic                       supervisorGood,
    input  wire logic                       seqDownActive,
    input  wire logic [CHANNELS-1:0]        seqSelected,
    input  wire logic [CHANNELS-1:0]        positionMembers,
    input  wire logic [CHANNELS-1:0]        belowDischarge,
    input  wire logic [CHANNELS-1:0]        fallTimeElapsed,
    input  wire logic [CHANNELS-1:0]        fallTimerInfinite,
    output logic                            onState,
    output logic                            sequenceUpStart,
    output logic                            position_advance_clock,
    output logic                            system_reset_out_n,
    output logic                            systemResetOe,
    output logic [RANGE_W-1:0]              rangeSelect,
    output logic [CHANNELS*STEP_W-1:0]      stepMv,
    output logic [CHANNELS-1:0]             dischargeNegative
);
    logic [2:0]        pinLevels;
    logic              pinGuardLevel;
    logic              onLevel;
    logic              marginPinN;
    logic              soft_write_guard;
    logic [KEY_W-1:0]  unlockKey;
    logic [15:0]       customerCode;
    logic [CTRL_W-1:0] control;
    logic              locked;
    logic              guardWrite;
    logic              keyMatch;
    logic              cfgWrite;
    logic              onInput;
    logic              next_onState;
    logic              advanceReady;
    logic              advanceReadyPrev;
    logic              releaseReset;
    logic              allDischarged;

    pin_sync #(
        .WIDTH (3),
        .INIT  (3'h4)
    ) u_pin_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pinIn ({margin_input_n, onPin, writeProtectPin}),
        .level (pinLevels)
    );

    assign pinGuardLevel = pinLevels[0];
    assign onLevel       = pinLevels[1];
    assign marginPinN    = pinLevels[2];

    range_decode u_range_decode (
        .clock             (clock),
        .rst_n             (rst_n),
        .rangeSel          (rangeSelect),
        .stepMv            (stepMv),
        .dischargeNegative (dischargeNegative)
    );

    // Write protection
    assign locked     = soft_write_guard | pinGuardLevel;
    assign guardWrite = cmd.valid & cmd.write & (cmd.code == CMD_WRITE_GUARD);
    assign keyMatch   = (cmd.data[15:KEY_LSB] == unlockKey)
                      & (cmd.data[GUARD_PIN_BIT:GUARD_SOFT_BIT] == 2'h0);
    assign cfgWrite   = cmd.valid & cmd.write & !locked;

    // Pin lock also blocks unlocking, so a held pin always wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            soft_write_guard <= SOFT_RESET;
        end else if (guardWrite && !pinGuardLevel) begin
            if (soft_write_guard) begin
                if (keyMatch) begin
                    soft_write_guard <= 1'b0;
                end
            end else begin
                soft_write_guard <= cmd.data[GUARD_SOFT_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            unlockKey <= KEY_RESET;
        end else if (guardWrite && !locked) begin
            unlockKey <= cmd.data[15:KEY_LSB];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            customerCode <= CUSTOMER_RESET;
        end else if (cfgWrite && cmd.code == CMD_CUSTOMER) begin
            customerCode <= cmd.data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            control <= CTRL_RESET;
        end else if (cfgWrite && cmd.code == CMD_ONOFF) begin
            control <= cmd.data[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rangeSelect <= RANGE_RESET;
        end else if (cfgWrite && cmd.code == CMD_RANGE) begin
            rangeSelect <= cmd.data[RANGE_W-1:0];
        end
    end

    // Reads are never gated; every command is acknowledged
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            resp <= '0;
        end else begin
            resp.ack <= cmd.valid;
            if (cmd.valid && !cmd.write) begin
                unique case (cmd.code)
                    CMD_WRITE_GUARD:
                        resp.data <= {unlockKey, pinGuardLevel,
                                      soft_write_guard};
                    CMD_CUSTOMER:
                        resp.data <= customerCode;
                    CMD_ONOFF:
                        resp.data <= {8'h00, onState, control[6:0]};
                    CMD_RANGE:
                        resp.data <= {4'h0, rangeSelect};
                    default:
                        resp.data <= 16'h0000;
                endcase
            end
        end
    end

    // Internal on state
    assign onInput = onLevel ^ control[POLARITY_BIT];

    always_comb begin
        unique case ({control[SER_MASK_BIT], control[ON_MASK_BIT]})
            2'h0: next_onState = 1'b0;
            2'h2: next_onState = control[SER_ON_BIT];
            2'h1: next_onState = onInput;
            default: next_onState = control[SER_ON_BIT] & onInput;
        endcase
    end

    // Freeze holds the last decision rather than forcing a level
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            onState <= 1'b0;
        end else if (!freezeMode) begin
            onState <= next_onState;
        end
    end

    assign allDischarged = &(belowDischarge | ~seqSelected);
    assign sequenceUpStart = onState
                           & (!control[DISCH_START_BIT] | allDischarged);

    // Margin and reset output, open drain: enable means pulling low
    assign releaseReset = control[MARGIN_BIT] | !marginPinN
                        | supervisorGood;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            system_reset_out_n <= 1'b0;
            systemResetOe      <= 1'b1;
        end else begin
            system_reset_out_n <= releaseReset;
            systemResetOe      <= !releaseReset;
        end
    end

    // Position advance during sequence-down
    always_comb begin
        advanceReady = seqDownActive;
        for (int c = 0; c < CHANNELS; c++) begin
            if (positionMembers[c]) begin
                if (control[SEQ_QUAL_BIT] && !fallTimerInfinite[c]) begin
                    advanceReady = advanceReady & fallTimeElapsed[c];
                end else begin
                    advanceReady = advanceReady & belowDischarge[c];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            advanceReadyPrev       <= 1'b0;
            position_advance_clock <= 1'b0;
        end else begin
            advanceReadyPrev       <= advanceReady;
            position_advance_clock <= advanceReady & !advanceReadyPrev;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_LOCKED_WRITE_HELD: assert property (
        cmd.valid && cmd.write && cmd.code == CMD_CUSTOMER && locked
        |=> $stable(customerCode))
        else $error("customer word changed while locked");

    AST_UNLOCK_ON_MATCH: assert property (
        guardWrite && soft_write_guard && keyMatch && !pinGuardLevel
        |=> !soft_write_guard)
        else $error("matching key did not clear soft lock");

    AST_NO_UNLOCK_MISMATCH: assert property (
        guardWrite && soft_write_guard && !keyMatch
        |=> soft_write_guard)
        else $error("soft lock cleared without key match");

    AST_PIN_READBACK: assert property (
        cmd.valid && !cmd.write && cmd.code == CMD_WRITE_GUARD
        |=> resp.data[GUARD_PIN_BIT] == $past(pinGuardLevel))
        else $error("guard read lost pin level");

    AST_KEY_HELD_LOCKED: assert property (
        locked |=> $stable(unlockKey))
        else $error("unlock key changed while locked");

    AST_ACK_EVERY_COMMAND: assert property (
        cmd.valid |=> resp.ack)
        else $error("command not acknowledged");

    AST_MASKS_OFF: assert property (
        !control[SER_MASK_BIT] && !control[ON_MASK_BIT] && !freezeMode
        |=> !onState)
        else $error("on state high with both masks clear");

    AST_POLARITY_NOW: assert property (
        control[ON_MASK_BIT] && !control[SER_MASK_BIT] && !freezeMode
        |=> onState == ($past(onLevel) ^ $past(control[POLARITY_BIT])))
        else $error("on state ignores pin polarity");

    AST_FREEZE_HOLDS: assert property (
        freezeMode |=> $stable(onState))
        else $error("on state moved during freeze");

    AST_MARGIN_RELEASE: assert property (
        control[MARGIN_BIT] |=> system_reset_out_n && !systemResetOe)
        else $error("margin did not release reset output");

    AST_DISCHARGE_GATE: assert property (
        sequenceUpStart && control[DISCH_START_BIT] |-> allDischarged)
        else $error("sequence-up with supplies charged");

    AST_ADVANCE_PULSE: assert property (
        position_advance_clock |=> !position_advance_clock)
        else $error("advance pulse longer than one cycle");

    AST_RESERVED_ZERO: assert property (
        cmd.valid && !cmd.write && cmd.code == CMD_ONOFF
        |=> resp.data[15:8] == 8'h00)
        else $error("reserved control bits not zero");

    AST_KEY_LOAD_UNLOCKED: assert property (
        guardWrite && !locked
        |=> unlockKey == $past(cmd.data[15:KEY_LSB]))
        else $error("unlocked guard write did not load key");

    AST_RELOCK_FROM_WRITE: assert property (
        guardWrite && !locked
        |=> soft_write_guard == $past(cmd.data[GUARD_SOFT_BIT]))
        else $error("unlocked guard write lost lock bit");

    AST_PIN_BLOCKS_GUARD: assert property (
        guardWrite && pinGuardLevel
        |=> $stable(soft_write_guard) && $stable(unlockKey))
        else $error("guard word changed under pin lock");

    AST_CUSTOMER_WRITE: assert property (
        cmd.valid && cmd.write && cmd.code == CMD_CUSTOMER && !locked
        |=> customerCode == $past(cmd.data))
        else $error("unlocked customer write lost");

    AST_RANGE_HELD_LOCKED: assert property (
        cmd.valid && cmd.write && cmd.code == CMD_RANGE && locked
        |=> $stable(rangeSelect))
        else $error("range word changed while locked");

    AST_NO_STRAY_ACK: assert property (
        !cmd.valid
        |=> !resp.ack)
        else $error("acknowledge without command");

    AST_UNMAPPED_ZERO: assert property (
        cmd.valid && !cmd.write && cmd.code > CMD_RANGE
        |=> resp.data == 16'h0000)
        else $error("unmapped command read not zero");

    AST_RANGE_RESERVED_ZERO: assert property (
        cmd.valid && !cmd.write && cmd.code == CMD_RANGE
        |=> resp.data[15:12] == 4'h0)
        else $error("reserved range bits not zero");

    AST_ONSTATE_READBACK: assert property (
        cmd.valid && !cmd.write && cmd.code == CMD_ONOFF
        |=> resp.data[7] == $past(onState))
        else $error("control read lost on state");

    AST_MARGIN_PIN_RELEASE: assert property (
        !marginPinN
        |=> system_reset_out_n && !systemResetOe)
        else $error("margin pin did not release reset output");
endmodule : sequencer_control_config_regs
`default_nettype wire

// >>> bench/host_model.sv
// Register host model: issues one command word and collects the answer
`default_nettype none
module host_model
    import seq_cfg_pkg::*;
(
    input  wire logic  clock,
    output var  cmd_t  cmd,
    input  wire resp_t resp
);
    timeunit 1ns;
    timeprecision 100ps;

    initial cmd = '0;

    // Idle cycle before each strobe keeps every command a one-cycle pulse
    task automatic access(input logic wr, input logic [7:0] code,
                          input logic [15:0] wdata, input int gap,
                          output logic [15:0] rdata, output logic ackOk);
        repeat (gap) @(posedge clock);
        @(posedge clock);
        #1;
        cmd = '{valid: 1'b1, write: wr, code: code, data: wdata};
        @(posedge clock);
        #1;
        // Released lines must not keep showing the old word
        cmd = '{valid: 1'b0, write: ~wr, code: ~code, data: ~wdata};
        ackOk = resp.ack;
        rdata = resp.data;
    endtask : access
endmodule : host_model
`default_nettype wire

// >>> bench/tb_sequencer_control_config_regs.sv
// Self-checking bench for the sequencer configuration register bank
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    mismatches++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_sequencer_control_config_regs
    import seq_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                       clock;
    logic                       rst_n;
    logic                       wpPin, onPin, marginN, freeze, supGood;
    logic                       seqDown;
    logic [CHANNELS-1:0]        seqSel, members, below, elapsed, infinite;
    cmd_t                       cmd;
    resp_t                      resp;
    logic                       onState, upStart, advance, resetOutN;
    logic                       resetOe;
    logic [RANGE_W-1:0]         rangeSel;
    logic [CHANNELS*STEP_W-1:0] stepMv;
    logic [CHANNELS-1:0]        dischNeg;
    logic [15:0]                rd;
    logic                       ok;
    logic [3:0]                 n;
    int                         gap = 0;
    int                         mismatches = 0;
    int                         cmp_count = 0;

    host_model HOST (.clock(clock), .cmd(cmd), .resp(resp));

    sequencer_control_config_regs DUT (
        .clock(clock), .rst_n(rst_n), .cmd(cmd), .resp(resp),
        .writeProtectPin(wpPin), .onPin(onPin), .margin_input_n(marginN),
        .freezeMode(freeze), .supervisorGood(supGood),
        .seqDownActive(seqDown), .seqSelected(seqSel),
        .positionMembers(members), .belowDischarge(below),
        .fallTimeElapsed(elapsed), .fallTimerInfinite(infinite),
        .onState(onState), .sequenceUpStart(upStart),
        .position_advance_clock(advance),
        .system_reset_out_n(resetOutN), .systemResetOe(resetOe),
        .rangeSelect(rangeSel), .stepMv(stepMv), .dischargeNegative(dischNeg)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic waitCyc(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : waitCyc

    task automatic wr(input logic [7:0] code, input logic [15:0] d);
        HOST.access(1'b1, code, d, gap, rd, ok);
        `CHK("writeAck", 1'b1, ok)
    endtask : wr

    task automatic rdChk(input logic [7:0] code, input logic [15:0] exp);
        HOST.access(1'b0, code, 16'h0000, gap, rd, ok);
        `CHK("readAck", 1'b1, ok)
        `CHK("readWord", exp, rd)
    endtask : rdChk

    task automatic chkRst(input logic rel);
        `CHK("resetOut", rel, resetOutN)
        `CHK("resetOe", ~rel, resetOe)
    endtask : chkRst

    task automatic countAdv();
        n = 4'h0;
        repeat (8) begin
            waitCyc(1);
            n = n + {3'b000, advance};
        end
    endtask : countAdv

    task automatic test_reset();
        rdChk(CMD_WRITE_GUARD, 16'h3aa9);
        rdChk(CMD_CUSTOMER, 16'h0000);
        rdChk(CMD_ONOFF, 16'h0000);
        rdChk(CMD_RANGE, 16'h0055);
        rdChk(8'h07, 16'h0000);
        `CHK("range", 12'h055, rangeSel)
        chkRst(1'b0);
    endtask : test_reset

    task automatic test_lock();
        wr(CMD_CUSTOMER, 16'h1234);
        wr(CMD_RANGE, 16'h0fff);
        rdChk(CMD_CUSTOMER, 16'h0000);
        rdChk(CMD_RANGE, 16'h0055);
        wr(CMD_WRITE_GUARD, {14'h0eab, 2'b00});
        rdChk(CMD_WRITE_GUARD, 16'h3aa9);
        wr(CMD_WRITE_GUARD, {14'h0eaa, 2'b10});
        rdChk(CMD_WRITE_GUARD, 16'h3aa9);
        wr(CMD_WRITE_GUARD, {14'h0eaa, 2'b00});
        rdChk(CMD_WRITE_GUARD, 16'h3aa8);
        gap = 3;
        wr(CMD_CUSTOMER, 16'hbeef);
        rdChk(CMD_CUSTOMER, 16'hbeef);
        gap = 0;
        wr(CMD_WRITE_GUARD, {14'h1235, 2'b01});
        rdChk(CMD_WRITE_GUARD, {14'h1235, 2'b01});
        wr(CMD_WRITE_GUARD, {14'h0eaa, 2'b00});
        rdChk(CMD_WRITE_GUARD, {14'h1235, 2'b01});
        wr(CMD_WRITE_GUARD, {14'h1235, 2'b00});
        rdChk(CMD_WRITE_GUARD, {14'h1235, 2'b00});
    endtask : test_lock

    task automatic test_pin();
        wpPin = 1'b1;
        waitCyc(5);
        rdChk(CMD_WRITE_GUARD, {14'h1235, 2'b10});
        wr(CMD_CUSTOMER, 16'h5555);
        rdChk(CMD_CUSTOMER, 16'hbeef);
        wr(CMD_WRITE_GUARD, {14'h0001, 2'b00});
        wpPin = 1'b0;
        waitCyc(5);
        rdChk(CMD_WRITE_GUARD, {14'h1235, 2'b00});
    endtask : test_pin

    task automatic test_range();
        wr(CMD_RANGE, 16'hf1b4);
        waitCyc(3);
        rdChk(CMD_RANGE, 16'h01b4);
        `CHK("range", 12'h1b4, rangeSel)
        `CHK("step", {5'h14, 5'h0a, 5'h04, 5'h04, 5'h0a, 5'h14}, stepMv)
        `CHK("dischNeg", 6'h04, dischNeg)
    endtask : test_range

    task automatic test_onoff();
        logic [4:0] v;
        logic [6:0] ctrl;
        logic       pinOn;
        logic       expOn;
        for (int i = 0; i < 32; i++) begin
            v = i[4:0];
            ctrl = {2'b00, v[0], v[1], v[2], v[3], 1'b0};
            wr(CMD_ONOFF, {9'h000, ctrl & 7'h7b});
            wr(CMD_ONOFF, {9'h1ff, ctrl});
            onPin = v[4];
            waitCyc(6);
            pinOn = v[4] ^ v[3];
            case ({v[1], v[2]})
                2'b00: expOn = 1'b0;
                2'b10: expOn = v[0];
                2'b01: expOn = pinOn;
                default: expOn = v[0] & pinOn;
            endcase
            `CHK("onState", expOn, onState)
            rdChk(CMD_ONOFF, {8'h00, expOn, ctrl});
        end
        freeze = 1'b1;
        wr(CMD_ONOFF, 16'h0018);
        waitCyc(3);
        `CHK("frozen", 1'b0, onState)
        freeze = 1'b0;
        waitCyc(2);
        `CHK("thawed", 1'b1, onState)
    endtask : test_onoff

    task automatic test_start();
        seqSel = 6'h21;
        below = 6'h20;
        wr(CMD_ONOFF, 16'h0038);
        waitCyc(2);
        `CHK("upStart", 1'b0, upStart)
        below = 6'h21;
        #1;
        `CHK("upStart", 1'b1, upStart)
        below = 6'h00;
        wr(CMD_ONOFF, 16'h0018);
        waitCyc(2);
        `CHK("upStart", 1'b1, upStart)
    endtask : test_start

    task automatic test_margin();
        waitCyc(2);
        chkRst(1'b0);
        wr(CMD_ONOFF, 16'h0058);
        waitCyc(2);
        chkRst(1'b1);
        wr(CMD_ONOFF, 16'h0018);
        marginN = 1'b0;
        waitCyc(6);
        chkRst(1'b1);
        marginN = 1'b1;
        waitCyc(6);
        chkRst(1'b0);
        supGood = 1'b1;
        waitCyc(2);
        chkRst(1'b1);
    endtask : test_margin

    task automatic test_advance();
        seqDown = 1'b1;
        members = 6'h03;
        below = 6'h01;
        wr(CMD_ONOFF, 16'h0000);
        countAdv();
        `CHK("advance", 4'h0, n)
        below = 6'h03;
        countAdv();
        `CHK("advance", 4'h1, n)
        below = 6'h00;
        wr(CMD_ONOFF, 16'h0001);
        elapsed = 6'h03;
        infinite = 6'h02;
        countAdv();
        `CHK("advance", 4'h0, n)
        below = 6'h02;
        countAdv();
        `CHK("advance", 4'h1, n)
    endtask : test_advance

    // Mid-run reset must bring every word back to its default
    task automatic test_rerun();
        rst_n = 1'b0;
        supGood = 1'b0;
        waitCyc(20);
        `CHK("onReset", 1'b0, onState)
        rst_n = 1'b1;
        test_reset();
    endtask : test_rerun

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    initial begin
        rst_n = 1'b0;
        {wpPin, onPin, freeze, supGood, seqDown} = 5'h00;
        marginN = 1'b1;
        {seqSel, members, below, elapsed, infinite} = '0;
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        test_reset();
        test_lock();
        test_pin();
        test_range();
        test_onoff();
        test_start();
        test_margin();
        test_advance();
        test_rerun();
        end_of_test();
    end

    // Whole run needs about six hundred cycles; this leaves wide margin
    initial begin
        #300000;
        mismatches++;
        end_of_test();
    end
endmodule : tb_sequencer_control_config_regs
`default_nettype wire
